/* File: pkg/crc_pkg.sv */
package crc_pkg;

  // Register byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RDY_TEST = 8'h08;
  localparam logic [7:0] REG_FCOL_TEST = 8'h0C;
  localparam logic [7:0] REG_EOF_TEST = 8'h10;
  localparam logic [7:0] REG_INT_STAT = 8'h14;
  localparam logic [7:0] REG_INT_MASK = 8'h18;

  // Command codes, compared on the low 15 bits of a command write
  localparam logic [14:0] CMD_READ_DEC = 15'h0586;
  localparam logic [14:0] CMD_READ_BIN = 15'h0786;
  localparam logic [14:0] CMD_SKIP_REM = 15'h1406;

  // Status register fields
  localparam int ST_B_READY = 0;
  localparam int ST_B_BUSY = 1;
  localparam int ST_B_BINARY = 2;
  localparam int ST_B_SKIP = 3;
  localparam int ST_B_EOF = 4;
  localparam int ST_B_VALID = 5;
  localparam int ST_B_FEED = 6;
  localparam int ST_B_READ = 7;
  localparam int ST_B_CHERR = 8;
  localparam int ST_B_COL = 16;
  localparam int STATUS_CLR_BIT = 0;

  // Interrupt status and mask fields
  localparam int IRQ_W = 4;
  localparam int IRQ_EOR = 0;
  localparam int IRQ_VALID = 1;
  localparam int IRQ_CHECK = 2;
  localparam int IRQ_RATE = 3;
  localparam logic [IRQ_W-1:0] INT_MASK_RST = 4'h0;

  // Card geometry
  localparam logic [7:0] COLS_PER_CARD = 8'h50;
  localparam logic [5:0] BLANK_CODE = 6'h30;

  // Timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int FEED_TIME_US = 85000;
  localparam int FCOL_TIME_US = 1200;
  localparam int FEED_CYC = (FEED_TIME_US / CLK_PERIOD_PS) * 1000000
                            + ((FEED_TIME_US % CLK_PERIOD_PS) * 1000000) / CLK_PERIOD_PS;
  localparam int FCOL_CYC = (FCOL_TIME_US * 1000) / (CLK_PERIOD_PS / 1000);
  localparam int CNT_W = 25;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_FEED = 5'h02,
    S_READ = 5'h04,
    S_SEND1 = 5'h08,
    S_SEND2 = 5'h10
  } crc_state_e;

  // Reader pins; rows[11]=row 12, rows[10]=row 11, rows[9]=row 0, rows[8:0]=rows 1..9
  typedef struct packed {
    logic power_on;
    logic hopper_empty;
    logic stacker_full;
    logic feed_fault;
    logic read_fault;
    logic start_sw;
    logic eof_enable;
    logic col_strobe;
    logic [11:0] rows;
  } crc_pins_s;

  typedef struct packed {
    logic [5:0] data;
    logic valid;
    logic eor;
    logic error;
    logic connected;
  } crc_chan_s;

endpackage

/* File: src/crc_coupler.sv */
// Behaviour
// - Ready read command reads one card from column 1, then end-of-record.
// - Hollerith mode sends one translated six-bit character per column.
// - Binary mode sends rows 12..3 then rows 4..9, top row MSB.
// - Decimal read command starts a feed and selects Hollerith.
// - Binary read command starts a feed and selects binary.
// - Format command between columns applies from the next column.
// - Skip-remainder stops delivery while the card keeps moving.
// - Skipped columns unchecked; checks and card end still interrupt, disconnect.
// - Ready test skips only when the reader is ready.
// - Ready needs power, cards, stacker room, healthy mechanics, start, idle.
// - About 85 ms pass between command and first column.
// - First-column test skips when under 1.2 ms remain.
// - End-of-file is hopper empty and enable on; test skips when absent.
// - End-of-file holds until cards are added or enable is off.
// - Card end disconnects, pulses end-of-record, stops motor, waits.
// - Invalid Hollerith column sets validity and channel error flags.
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module crc_coupler #(
  parameter int FEED_CYCLES = crc_pkg::FEED_CYC,
  parameter int FCOL_CYCLES = crc_pkg::FCOL_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire crc_pkg::crc_pins_s rdr_pins,
  output logic rdr_motor,
  output logic rdr_feed,
  output crc_pkg::crc_chan_s chan,
  input wire logic chan_ready,
  output logic irq
);
  import crc_pkg::*;

  localparam logic [CNT_W-1:0] FEED_LOAD = CNT_W'(FEED_CYCLES - 1);
  localparam logic [CNT_W-1:0] FCOL_LIM = CNT_W'(FCOL_CYCLES);

  typedef struct packed {
    crc_state_e st;
    crc_pins_s pin_meta;
    crc_pins_s pin_sync;
    logic strobe_d;
    logic started;
    logic binary;
    logic skipping;
    logic valid_chk;
    logic feed_chk;
    logic read_chk;
    logic chan_err;
    logic [CNT_W-1:0] cnt;
    logic [7:0] col;
    logic [5:0] second;
    // Format of the column in flight, so a mid-card format change never splits it
    logic col_bin;
    crc_chan_s chan;
    logic motor;
    logic feed_go;
    logic [IRQ_W-1:0] int_stat;
    logic [IRQ_W-1:0] int_mask;
    logic [23:0] last_cmd;
    logic ack;
    logic [31:0] rdata;
    logic slverr;
  } crc_regs_s;

  crc_regs_s r_ff;
  crc_regs_s nxt_r;

  // Returns {invalid, code}; more than one digit or zone punch is invalid
  function automatic logic [6:0] holl_xlate(input logic [11:0] c);
    logic [3:0] d;
    logic [1:0] zv;
    logic bad;
    d = 4'h0;
    zv = 2'b00;
    bad = ($countones(c[8:0]) > 1) || ($countones(c[11:9]) > 1);
    for (int i = 0; i < 9; i++) begin
      if (c[8-i]) begin
        d = 4'(i + 1);
      end
    end
    if (c[11]) begin
      zv = 2'b11;
    end else if (c[10]) begin
      zv = 2'b10;
    end else if (c[9] && (c[8:0] != 9'h000)) begin
      zv = 2'b01;
    end
    if (c == 12'h000) begin
      holl_xlate = {1'b0, BLANK_CODE};
    end else begin
      holl_xlate = {bad, zv, d};
    end
  endfunction

  logic ready;
  logic eof_cond;
  logic fcol_due;
  logic col_edge;
  logic fault;
  logic acc;
  logic wr_done;
  logic rd_done;
  logic [6:0] hx;
  logic [31:0] status_word;

  always_comb begin
    ready = r_ff.pin_sync.power_on && !r_ff.pin_sync.hopper_empty
            && !r_ff.pin_sync.stacker_full && !r_ff.pin_sync.feed_fault
            && !r_ff.pin_sync.read_fault && !r_ff.feed_chk && !r_ff.read_chk
            && r_ff.started && (r_ff.st == S_IDLE);
    eof_cond = r_ff.pin_sync.hopper_empty && r_ff.pin_sync.eof_enable;
    // Due near the end of the feed wait, or while column one is still awaited
    fcol_due = ((r_ff.st == S_FEED) && (r_ff.cnt < FCOL_LIM))
               || ((r_ff.st == S_READ) && (r_ff.col == 8'h00));
    col_edge = r_ff.pin_sync.col_strobe && !r_ff.strobe_d;
    fault = r_ff.pin_sync.feed_fault || r_ff.pin_sync.read_fault;
    hx = holl_xlate(r_ff.pin_sync.rows);
    acc = psel && penable && r_ff.ack;
    wr_done = acc && pwrite;
    rd_done = acc && !pwrite;
    status_word = 32'h0;
    status_word[ST_B_READY] = ready;
    status_word[ST_B_BUSY] = r_ff.chan.connected;
    status_word[ST_B_BINARY] = r_ff.binary;
    status_word[ST_B_SKIP] = r_ff.skipping;
    status_word[ST_B_EOF] = eof_cond;
    status_word[ST_B_VALID] = r_ff.valid_chk;
    status_word[ST_B_FEED] = r_ff.feed_chk;
    status_word[ST_B_READ] = r_ff.read_chk;
    status_word[ST_B_CHERR] = r_ff.chan_err;
    status_word[ST_B_COL +: 8] = r_ff.col;
  end

  always_comb begin
    nxt_r = r_ff;
    nxt_r.pin_meta = rdr_pins;
    nxt_r.pin_sync = r_ff.pin_meta;
    nxt_r.strobe_d = r_ff.pin_sync.col_strobe;
    nxt_r.chan.eor = 1'b0;
    nxt_r.feed_go = 1'b0;
    // Start latch drops with power, as the operator must press start again
    if (!r_ff.pin_sync.power_on) begin
      nxt_r.started = 1'b0;
    end else if (r_ff.pin_sync.start_sw) begin
      nxt_r.started = 1'b1;
    end

    // Bus slave: one wait state so read data comes from a flip-flop
    nxt_r.ack = psel && penable && !r_ff.ack;
    if (psel && penable && !r_ff.ack) begin
      nxt_r.slverr = 1'b0;
      nxt_r.rdata = 32'h0;
      case (paddr)
        REG_CMD: nxt_r.rdata = {8'h00, r_ff.last_cmd};
        REG_STATUS: nxt_r.rdata = status_word;
        REG_RDY_TEST: nxt_r.rdata = {31'h0, ready};
        REG_FCOL_TEST: nxt_r.rdata = {31'h0, fcol_due};
        REG_EOF_TEST: nxt_r.rdata = {31'h0, !eof_cond};
        REG_INT_STAT: nxt_r.rdata = {28'h0, r_ff.int_stat};
        REG_INT_MASK: nxt_r.rdata = {28'h0, r_ff.int_mask};
        default: nxt_r.slverr = 1'b1;
      endcase
    end
    // Clear only what the read returned; an event after capture stays pending
    if (rd_done && (paddr == REG_INT_STAT)) begin
      nxt_r.int_stat = r_ff.int_stat & ~r_ff.rdata[IRQ_W-1:0];
    end
    if (wr_done && (paddr == REG_INT_MASK)) begin
      nxt_r.int_mask = pwdata[IRQ_W-1:0];
    end
    if (wr_done && (paddr == REG_STATUS) && pwdata[STATUS_CLR_BIT]) begin
      nxt_r.valid_chk = 1'b0;
      nxt_r.feed_chk = 1'b0;
      nxt_r.read_chk = 1'b0;
      nxt_r.chan_err = 1'b0;
    end
    if (wr_done && (paddr == REG_CMD)) begin
      nxt_r.last_cmd = pwdata[23:0];
      if ((pwdata[14:0] == CMD_READ_DEC) || (pwdata[14:0] == CMD_READ_BIN)) begin
        if (r_ff.st != S_IDLE) begin
          nxt_r.binary = (pwdata[14:0] == CMD_READ_BIN);
        end else if (ready) begin
          nxt_r.binary = (pwdata[14:0] == CMD_READ_BIN);
          nxt_r.st = S_FEED;
          nxt_r.cnt = FEED_LOAD;
          nxt_r.col = 8'h00;
          nxt_r.skipping = 1'b0;
          nxt_r.motor = 1'b1;
          nxt_r.feed_go = 1'b1;
          nxt_r.chan.connected = 1'b1;
        end
      end else if ((pwdata[14:0] == CMD_SKIP_REM) && (r_ff.st != S_IDLE)) begin
        nxt_r.skipping = 1'b1;
      end
    end

    case (r_ff.st)
      S_IDLE: begin
      end
      S_FEED: begin
        // Columns strobed while the card is still feeding are ignored
        if (r_ff.cnt == '0) begin
          nxt_r.st = S_READ;
        end else begin
          nxt_r.cnt = r_ff.cnt - 1'b1;
        end
      end
      S_READ: begin
        if (col_edge) begin
          nxt_r.col = r_ff.col + 1'b1;
          if (nxt_r.skipping) begin
            if (r_ff.col + 1'b1 == COLS_PER_CARD) begin
              nxt_r.st = S_IDLE;
            end
          end else if (r_ff.binary) begin
            nxt_r.chan.data = r_ff.pin_sync.rows[11:6];
            nxt_r.second = r_ff.pin_sync.rows[5:0];
            nxt_r.col_bin = 1'b1;
            nxt_r.chan.valid = 1'b1;
            nxt_r.st = S_SEND1;
          end else begin
            nxt_r.chan.data = hx[5:0];
            nxt_r.col_bin = 1'b0;
            nxt_r.chan.valid = 1'b1;
            nxt_r.st = S_SEND1;
            if (hx[6]) begin
              nxt_r.valid_chk = 1'b1;
              nxt_r.chan_err = 1'b1;
              nxt_r.int_stat[IRQ_VALID] = 1'b1;
            end
          end
        end
      end
      S_SEND1, S_SEND2: begin
        // A column that lands while the channel still holds a character is lost
        if (col_edge) begin
          nxt_r.chan_err = 1'b1;
          nxt_r.int_stat[IRQ_RATE] = 1'b1;
        end
        if (r_ff.skipping) begin
          nxt_r.chan.valid = 1'b0;
          nxt_r.st = (r_ff.col == COLS_PER_CARD) ? S_IDLE : S_READ;
        end else if (chan_ready) begin
          // Second half follows the format the column was read in
          if ((r_ff.st == S_SEND1) && r_ff.col_bin) begin
            nxt_r.chan.data = r_ff.second;
            nxt_r.st = S_SEND2;
          end else begin
            nxt_r.chan.valid = 1'b0;
            nxt_r.st = (r_ff.col == COLS_PER_CARD) ? S_IDLE : S_READ;
          end
        end
      end
      default: nxt_r.st = S_IDLE;
    endcase

    // Mechanical faults abort the card even while skipping
    if ((r_ff.st != S_IDLE) && fault) begin
      nxt_r.feed_chk = r_ff.feed_chk || r_ff.pin_sync.feed_fault;
      nxt_r.read_chk = r_ff.read_chk || r_ff.pin_sync.read_fault;
      nxt_r.chan_err = 1'b1;
      nxt_r.int_stat[IRQ_CHECK] = 1'b1;
      nxt_r.st = S_IDLE;
      nxt_r.chan.valid = 1'b0;
    end
    if ((r_ff.st != S_IDLE) && (nxt_r.st == S_IDLE)) begin
      nxt_r.chan.connected = 1'b0;
      nxt_r.chan.eor = 1'b1;
      nxt_r.motor = 1'b0;
      nxt_r.int_stat[IRQ_EOR] = 1'b1;
    end
    nxt_r.chan.error = nxt_r.chan_err;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_ff <= '{st: S_IDLE, int_mask: INT_MASK_RST, default: '0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign prdata = r_ff.rdata;
  assign pready = r_ff.ack;
  assign pslverr = r_ff.ack && r_ff.slverr;
  assign rdr_motor = r_ff.motor;
  assign rdr_feed = r_ff.feed_go;
  assign chan = r_ff.chan;
  assign irq = |(r_ff.int_stat & r_ff.int_mask);

endmodule

/* File: dv/crc_reader_model.sv */
`timescale 1ns/1ps
module crc_reader_model (
  input wire logic pclk,
  input wire logic rdr_motor,
  input wire crc_pkg::crc_pins_s sw_pins,
  input wire logic [11:0] row_pat,
  output crc_pkg::crc_pins_s pins
);
  import crc_pkg::*;
  logic [3:0] ph_ff;
  // Cards move only while the motor turns; a column passes every 16 cycles
  always_ff @(posedge pclk) ph_ff <= rdr_motor ? ph_ff + 4'h1 : 4'h0;
  always_comb begin
    pins = sw_pins;
    pins.col_strobe = rdr_motor && ph_ff[3];
    // Rows held for the whole card so the two-flop sync never sees a change
    pins.rows = row_pat;
  end
endmodule

/* File: dv/crc_coupler_props.sv */
`timescale 1ns/1ps
module crc_coupler_props #(
  parameter int FEED_CYCLES = 200,
  parameter int FCOL_CYCLES = 50
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire crc_pkg::crc_pins_s rdr_pins,
  input wire logic rdr_motor,
  input wire logic rdr_feed,
  input wire crc_pkg::crc_chan_s chan,
  input wire logic chan_ready,
  input wire logic irq
);
  import crc_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Cycles since the last feed pulse, saturating at the feed wait
  int since_feed;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_feed <= 0;
    end else if (rdr_feed) begin
      since_feed <= 0;
    end else if (since_feed < FEED_CYCLES) begin
      since_feed <= since_feed + 1;
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  a_one_wait: assert property (s_setup ##1 s_access |=> pready)
    else $error("pready not one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_char_holds: assert property (chan.valid && !chan_ready && !(psel && pwrite)
    && !$past(psel && pwrite) |=> (chan.valid && $stable(chan.data)) || !chan.connected)
    else $error("character dropped");
  a_feed_wait: assert property (chan.valid |-> since_feed >= FEED_CYCLES)
    else $error("column delivered before feed wait ended");
  a_eor_pulse: assert property (chan.eor |=> !chan.eor)
    else $error("end of record too long");
  a_feed_starts: assert property (rdr_feed |=> !rdr_feed && rdr_motor)
    else $error("feed pulse wrong");
  a_end_stops: assert property ($fell(chan.connected) |-> ##[0:2] !rdr_motor)
    else $error("motor left running");
  a_idle_silent: assert property (!chan.connected |-> !chan.valid)
    else $error("character while disconnected");
  a_busy_unready: assert property (psel && pready && !pwrite && paddr == REG_RDY_TEST
    && chan.connected |-> !prdata[0]) else $error("ready during card");
endmodule

bind crc_coupler crc_coupler_props #(.FEED_CYCLES(FEED_CYCLES), .FCOL_CYCLES(FCOL_CYCLES))
  i_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .rdr_pins, .rdr_motor, .rdr_feed, .chan, .chan_ready, .irq);

/* File: dv/crc_coupler_tb.sv */
`timescale 1ns/1ps
module crc_coupler_tb;
  import crc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic chan_ready = 1'b0;
  logic irq;
  logic rdr_motor;
  logic rdr_feed;
  logic [11:0] row_pat = 12'h000;
  crc_pins_s sw = '0;
  crc_pins_s pins;
  crc_chan_s chan;
  logic [5:0] got_q[$];
  logic [31:0] rd;
  int num_errors = 0;
  int comparisons = 0;
  always #2 pclk = ~pclk;
  // Channel stalls every other cycle so pending characters must be held
  always @(posedge pclk) chan_ready <= ~chan_ready;
  always @(negedge pclk) if (chan.valid === 1'b1 && chan_ready) got_q.push_back(chan.data);
  crc_reader_model i_rdr (.pclk, .rdr_motor, .sw_pins(sw), .row_pat, .pins);
  crc_coupler #(.FEED_CYCLES(200), .FCOL_CYCLES(50)) i_dut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rdr_pins(pins),
    .rdr_motor, .rdr_feed, .chan, .chan_ready, .irq);
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = pslverr ? 32'hFFFF_FFFF : prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_status;
    sw.hopper_empty <= 1'b1;
    sw.eof_enable <= 1'b1;
    apb(0, 8'h1C, 0);
    chk("unmapped", 32'hFFFF_FFFF, rd);
    apb(0, REG_RDY_TEST, 0);
    chk("ready empty", 0, rd[0]);
    apb(0, REG_EOF_TEST, 0);
    chk("eof set", 0, rd[0]);
    sw.eof_enable <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(0, REG_EOF_TEST, 0);
    chk("eof off", 1, rd[0]);
    sw.hopper_empty <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  task automatic t_card(input logic [14:0] cmd, input logic [11:0] r, input int cut,
                        input int n);
    int k;
    @(posedge pclk);
    row_pat <= r;
    got_q.delete();
    apb(0, REG_RDY_TEST, 0);
    chk("ready", 1, rd[0]);
    apb(1, REG_CMD, {17'h0, cmd});
    apb(0, REG_FCOL_TEST, 0);
    chk("fcol early", 0, rd[0]);
    repeat (170) @(posedge pclk);
    apb(0, REG_FCOL_TEST, 0);
    chk("fcol due", 1, rd[0]);
    for (k = 0; k < 3000 && got_q.size() < cut; k++) @(negedge pclk);
    if (cut > 0) apb(1, REG_CMD, {17'h0, CMD_SKIP_REM});
    for (k = 0; k < 3000 && chan.eor !== 1'b1; k++) @(negedge pclk);
    chk("eor", 1, chan.eor);
    chk("count", 1, cut > 0 ? got_q.size() <= n : got_q.size() == n);
    for (k = 0; k < got_q.size(); k++)
      chk("char", cmd == CMD_READ_BIN ? (k[0] ? r[5:0] : r[11:6]) : BLANK_CODE, got_q[k]);
    @(negedge pclk);
    chk("irq", 1, irq);
    apb(0, REG_INT_STAT, 0);
    chk("eor stat", 1, rd[IRQ_EOR]);
    @(negedge pclk);
    chk("irq clr", 0, irq);
  endtask
  task automatic t_mixed;
    int k;
    @(posedge pclk);
    row_pat <= 12'h100;
    got_q.delete();
    apb(0, REG_RDY_TEST, 0);
    chk("ready mix", 1, rd[0]);
    apb(1, REG_CMD, {17'h0, CMD_READ_DEC});
    for (k = 0; k < 3000 && got_q.size() < 3; k++) @(negedge pclk);
    apb(0, REG_STATUS, 0);
    chk("active", 1, rd[ST_B_BUSY]);
    apb(1, REG_CMD, {17'h0, CMD_READ_BIN});
    for (k = 0; k < 3000 && chan.eor !== 1'b1; k++) @(negedge pclk);
    chk("mix count", 157, got_q.size());
    for (k = 0; k < got_q.size(); k++)
      chk("mix char", k < 3 ? 6'h01 : (k[0] ? 6'h04 : 6'h00), got_q[k]);
  endtask
  task automatic t_invalid;
    int k;
    @(posedge pclk);
    row_pat <= 12'h003;
    apb(0, REG_RDY_TEST, 0);
    chk("ready inv", 1, rd[0]);
    apb(1, REG_CMD, {17'h0, CMD_READ_DEC});
    for (k = 0; k < 3000 && chan.eor !== 1'b1; k++) @(negedge pclk);
    chk("chan error", 1, chan.error);
    apb(0, REG_STATUS, 0);
    chk("validity", 1, rd[ST_B_VALID]);
    chk("cherr", 1, rd[ST_B_CHERR]);
    apb(0, REG_INT_STAT, 0);
    chk("valid stat", 1, rd[IRQ_VALID]);
    apb(1, REG_STATUS, 32'h0000_0001);
    apb(0, REG_STATUS, 0);
    chk("validity clr", 0, rd[ST_B_VALID]);
    chk("chan error clr", 0, chan.error);
  endtask
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    sw.power_on = 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    sw.start_sw <= 1'b1;
    repeat (4) @(posedge pclk);
    sw.start_sw <= 1'b0;
    t_status;
    apb(1, REG_INT_MASK, 32'h1);
    t_card(CMD_READ_DEC, 12'h000, 0, 80);
    t_card(CMD_READ_BIN, 12'hA53, 0, 160);
    t_card(CMD_READ_DEC, 12'h000, 5, 6);
    t_mixed;
    t_invalid;
    complete_run;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    complete_run;
  end
endmodule
